// ===== shared/cbx_cfg.svh
// Register offsets, opcode fields, reset values for the branch and indexed-op unit.
// Assumes byte addresses on a 32-bit classic Wishbone slave.
`ifndef CBX_CFG_SVH
`define CBX_CFG_SVH

// Register byte offsets
`define CBX_ADR_CTRL 8'h00
`define CBX_ADR_FLAGS 8'h04
`define CBX_ADR_PC 8'h08
`define CBX_ADR_WORKING_REGISTER 8'h0C
`define CBX_ADR_BSR 8'h10
`define CBX_ADR_PC_HIGH_LATCH 8'h14
`define CBX_ADR_PC_UPPER_LATCH 8'h18
`define CBX_ADR_FSR0 8'h1C
`define CBX_ADR_FSR1 8'h20
`define CBX_ADR_STACK_FRAME_POINTER 8'h24
`define CBX_ADR_INSTR2 8'h28
`define CBX_ADR_INSTR 8'h2C
`define CBX_ADR_STAT 8'h30
`define CBX_ADR_ICNT 8'h34
`define CBX_ADR_MADDR 8'h38
`define CBX_ADR_MDATA 8'h3C

// Field positions
`define CBX_CTRL_EXT_BIT 0
`define CBX_STAT_BUSY_BIT 0
`define CBX_STAT_ILL_BIT 1
`define CBX_STAT_SP_LSB 8

// Opcode upper bytes and fixed words
`define CBX_OP_BNC 8'hE3
`define CBX_OP_BNN 8'hE7
`define CBX_OP_BOV 8'hE4
`define CBX_OP_ADDF 8'hE8
`define CBX_OP_SUBF 8'hE9
`define CBX_OP_PUSH_LITERAL_OP 8'hEA
`define CBX_OP_MOVS 8'hEB
`define CBX_OP_CALL_VIA_WORKING_REG 16'h0014
`define CBX_PFX_BTG 4'h7
`define CBX_PFX_WORD2 4'hF
`define CBX_FSR_FRAME 2'h3

// Addressing limits
`define CBX_ILO_MAX 8'h5F
`define CBX_ACC_SPLIT 8'h60

// Program counter steps
`define CBX_PC_STEP1 21'h000002
`define CBX_PC_STEP2 21'h000004

// Reset values
`define CBX_RST_PC 21'h000000
`define CBX_RST_BYTE 8'h00
`define CBX_RST_EXT 1'b0

`endif

// ===== shared/cbx_pkg.sv
// Types shared by the branch and indexed-op unit.
// Assumes a 32-bit classic Wishbone slave with byte addressing.
package cbx_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXE = 2'b01,
    ST_SEC = 2'b11
  } cbx_state_t;

  typedef enum logic [3:0] {
    OP_OTHER, OP_BNC, OP_BNN, OP_BOV, OP_BTG, OP_ADDF, OP_SUBF,
    OP_PUSH_LITERAL_OP, OP_CALL_VIA_WORKING_REG, OP_INDEXED_TO_FILE_MOVE, OP_INDEXED_TO_INDEXED_MOVE
  } cbx_op_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cbx_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } cbx_wb_rsp_t;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } cbx_flags_t;

endpackage

// ===== rtl/cbx_ram.sv
// Simple dual-port memory, one write port and one registered read port.
// Assumes a single clock; read data lags the address by one edge.
`timescale 1ns/1ns
`default_nettype none
module cbx_ram #(
  parameter int W = 8,
  parameter int AW = 12
) (
  input wire logic core_clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] wa_in,
  input wire logic [W-1:0] wd_in,
  input wire logic [AW-1:0] ra_in,
  output var logic [W-1:0] rd_out
);

  logic [W-1:0] mem_r [2**AW];

  // Write then registered read
  always_ff @(posedge core_clk_in) begin
    if (we_in) begin
      mem_r[wa_in] <= wd_in;
    end
    rd_out <= mem_r[ra_in];
  end

endmodule
`default_nettype wire

// ===== rtl/cbx_exec.sv
// Executes one instruction word of the branch, bit-invert and extended group.
// Assumes a classic Wishbone slave; one instruction cycle per clock.
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`include "cbx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - carry-clear branch jumps only when carry is 0, flags untouched.
// - not-negative branch jumps only when negative is 0, flags untouched.
// - overflow branch jumps only when overflow is 1, flags untouched.
// - target is PC+2+2n; taken takes two cycles, untaken one.
// - bit-invert flips chosen bit of addressed byte over two cycles, read then write.
// - access bit 0 selects access bank and ignores bank select.
// - access bit 1 takes upper address from bank select register.
// - extended set, access 0, address up to 5Fh uses frame-indexed address.
// - extended ops and indexed mode exist only with extended enable set.
// - pointer add/sub adds or subtracts 6-bit literal, one cycle.
// - pointer field 11 works on frame pointer then returns.
// - add/sub-with-return takes two cycles, flags untouched.
// - push-literal stores at frame pointer then decrements it.
// - call-via-working-register takes two cycles, second idle, no flags.
// - indexed-to-file move, two words, frame-relative source, 12-bit destination.
// - indexed-to-indexed move, two words, both frame-relative, two cycles.
module cbx_exec #(
  parameter int STK_AW = 5,
  parameter int STK_DEPTH = 31,
  parameter int DM_AW = 12
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire cbx_pkg::cbx_wb_req_t wb_req_in,
  output var cbx_pkg::cbx_wb_rsp_t wb_rsp_out
);
  import cbx_pkg::*;

  localparam int BW = DM_AW - 8;

  cbx_state_t st_r, st_nxt;
  cbx_flags_t flags_r;
  logic [15:0] ins_r, ins2_r;
  logic [20:0] pc_r, pc_nxt;
  logic [7:0] working_register_r, pc_high_latch_r;
  logic [4:0] pc_upper_latch_r;
  logic [BW-1:0] bsr_r;
  logic [STK_AW-1:0] sp_r, sp_nxt;
  logic [31:0] icnt_r;
  logic [DM_AW-1:0] maddr_r;
  logic ext_en_r, ill_r, ill_set, ack_r;
  logic [31:0] rdat_r;
  logic [DM_AW-1:0] fsr_w [3];

  // Bus request decode
  wire logic req_w = wb_req_in.cyc && wb_req_in.stb && !ack_r;
  wire logic wr_w = req_w && wb_req_in.we;
  wire logic idle_w = (st_r == ST_IDLE);
  wire logic bw_w = wr_w && idle_w;
  wire logic [7:0] adr_w = wb_req_in.adr;
  wire logic [31:0] mask_w = {{8{wb_req_in.sel[3]}}, {8{wb_req_in.sel[2]}},
    {8{wb_req_in.sel[1]}}, {8{wb_req_in.sel[0]}}};
  wire logic go_w = bw_w && adr_w == `CBX_ADR_INSTR;

  // Instruction fields
  wire logic [7:0] hi_w = ins_r[15:8];
  wire logic [7:0] lo_w = ins_r[7:0];
  wire logic [2:0] bsel_w = ins_r[11:9];
  wire logic acc_w = ins_r[8];
  wire logic [1:0] fsel_w = ins_r[7:6];
  wire logic [DM_AW-1:0] k6_w = DM_AW'(ins_r[5:0]);
  wire logic ulnk_w = (fsel_w == `CBX_FSR_FRAME);
  wire logic w2ok_w = (ins2_r[15:12] == `CBX_PFX_WORD2);
  wire logic [DM_AW-1:0] stack_frame_pointer_w = fsr_w[2];

  // Opcode classification, extended group gated by the enable
  wire logic ext_hit_w = ext_en_r && (hi_w == `CBX_OP_ADDF || hi_w == `CBX_OP_SUBF
    || hi_w == `CBX_OP_PUSH_LITERAL_OP || hi_w == `CBX_OP_MOVS || ins_r == `CBX_OP_CALL_VIA_WORKING_REG);
  wire cbx_op_t cls_w =
    (hi_w == `CBX_OP_BNC) ? OP_BNC :
    (hi_w == `CBX_OP_BNN) ? OP_BNN :
    (hi_w == `CBX_OP_BOV) ? OP_BOV :
    (ins_r[15:12] == `CBX_PFX_BTG) ? OP_BTG :
    !ext_hit_w ? OP_OTHER :
    (hi_w == `CBX_OP_ADDF) ? OP_ADDF :
    (hi_w == `CBX_OP_SUBF) ? OP_SUBF :
    (hi_w == `CBX_OP_PUSH_LITERAL_OP) ? OP_PUSH_LITERAL_OP :
    (ins_r == `CBX_OP_CALL_VIA_WORKING_REG) ? OP_CALL_VIA_WORKING_REG :
    !w2ok_w ? OP_OTHER :
    ins_r[7] ? OP_INDEXED_TO_INDEXED_MOVE : OP_INDEXED_TO_FILE_MOVE;

  // Branch condition and relative target
  wire logic take_w = (cls_w == OP_BNC && !flags_r.c)
    || (cls_w == OP_BNN && !flags_r.n)
    || (cls_w == OP_BOV && flags_r.ov);
  wire logic [20:0] boff_w = {{12{lo_w[7]}}, lo_w, 1'b0};
  wire logic [20:0] btgt_w = pc_r + `CBX_PC_STEP1 + boff_w;
  wire logic [20:0] pc_inc_w = pc_r + `CBX_PC_STEP1;

  // Bit-invert effective address
  wire logic ilo_w = ext_en_r && !acc_w && lo_w <= `CBX_ILO_MAX;
  wire logic [DM_AW-1:0] ea_w =
    acc_w ? {bsr_r, lo_w} :
    ilo_w ? stack_frame_pointer_w + DM_AW'(lo_w) :
    (lo_w >= `CBX_ACC_SPLIT) ? {{BW{1'b1}}, lo_w} : {{BW{1'b0}}, lo_w};

  // Indexed move addresses
  wire logic [DM_AW-1:0] src_w = stack_frame_pointer_w + DM_AW'(ins_r[6:0]);
  wire logic [DM_AW-1:0] dst_w = (cls_w == OP_INDEXED_TO_INDEXED_MOVE) ?
    stack_frame_pointer_w + DM_AW'(ins2_r[6:0]) : ins2_r[DM_AW-1:0];

  // Data memory ports
  logic [7:0] dm_rd;
  logic [20:0] stk_rd;
  wire logic ex_sec_w = (st_r == ST_SEC);
  wire logic ex_exe_w = (st_r == ST_EXE);
  wire logic btg_w = (cls_w == OP_BTG);
  wire logic movs_w = (cls_w == OP_INDEXED_TO_FILE_MOVE || cls_w == OP_INDEXED_TO_INDEXED_MOVE);
  wire logic push_w = ex_exe_w && cls_w == OP_PUSH_LITERAL_OP;
  wire logic secwr_w = ex_sec_w && (btg_w || movs_w);
  wire logic bmem_w = bw_w && adr_w == `CBX_ADR_MDATA && wb_req_in.sel[0];
  wire logic [7:0] inv_w = dm_rd ^ (8'h01 << bsel_w);
  wire logic dm_we_w = secwr_w || push_w || bmem_w;
  wire logic [DM_AW-1:0] dm_wa_w = push_w ? stack_frame_pointer_w :
    !secwr_w ? maddr_r : btg_w ? ea_w : dst_w;
  wire logic [7:0] dm_wd_w = push_w ? lo_w : !secwr_w ? wb_req_in.dat[7:0] :
    btg_w ? inv_w : dm_rd;
  wire logic [DM_AW-1:0] dm_ra_w = !ex_exe_w ? maddr_r : btg_w ? ea_w : src_w;

  cbx_ram #(.W(8), .AW(DM_AW)) u_dmem (
    .core_clk_in(core_clk_in),
    .we_in(dm_we_w),
    .wa_in(dm_wa_w),
    .wd_in(dm_wd_w),
    .ra_in(dm_ra_w),
    .rd_out(dm_rd)
  );

  // Return stack, top entry always read at sp-1
  wire logic stk_full_w = (sp_r == STK_AW'(STK_DEPTH));
  wire logic stk_we_w = ex_exe_w && cls_w == OP_CALL_VIA_WORKING_REG && !stk_full_w;
  wire logic [STK_AW-1:0] tos_a_w = sp_r - STK_AW'(1);

  cbx_ram #(.W(21), .AW(STK_AW)) u_stack (
    .core_clk_in(core_clk_in),
    .we_in(stk_we_w),
    .wa_in(sp_r),
    .wd_in(pc_inc_w),
    .ra_in(tos_a_w),
    .rd_out(stk_rd)
  );

  // Execution sequencing
  always_comb begin
    st_nxt = st_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    ill_set = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (go_w) begin
          st_nxt = ST_EXE;
        end
      end
      ST_EXE: begin
        st_nxt = ST_IDLE;
        pc_nxt = pc_inc_w;
        case (cls_w)
          OP_BNC, OP_BNN, OP_BOV: begin
            if (take_w) begin
              pc_nxt = btgt_w;
              st_nxt = ST_SEC;
            end
          end
          OP_BTG, OP_INDEXED_TO_FILE_MOVE, OP_INDEXED_TO_INDEXED_MOVE: begin
            pc_nxt = pc_r;
            st_nxt = ST_SEC;
          end
          OP_ADDF, OP_SUBF: begin
            if (ulnk_w) begin
              pc_nxt = stk_rd;
              sp_nxt = tos_a_w;
              st_nxt = ST_SEC;
            end
          end
          OP_CALL_VIA_WORKING_REG: begin
            pc_nxt = {pc_upper_latch_r, pc_high_latch_r, working_register_r};
            st_nxt = ST_SEC;
            if (stk_full_w) begin
              ill_set = 1'b1;
            end else begin
              sp_nxt = sp_r + STK_AW'(1);
            end
          end
          OP_PUSH_LITERAL_OP: begin
            pc_nxt = pc_inc_w;
          end
          default: begin
            ill_set = 1'b1;
          end
        endcase
      end
      ST_SEC: begin
        st_nxt = ST_IDLE;
        if (btg_w) begin
          pc_nxt = pc_inc_w;
        end else if (movs_w) begin
          pc_nxt = pc_r + `CBX_PC_STEP2;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // Pointer registers, one per index
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_fsr
      logic [DM_AW-1:0] fsr_r;
      wire logic [1:0] tgt_w = ulnk_w ? 2'd2 : fsel_w;
      wire logic hit_w = bw_w && adr_w == (`CBX_ADR_FSR0 + 8'(4 * gi));
      wire logic lit_w = ex_exe_w && tgt_w == 2'(gi)
        && (cls_w == OP_ADDF || cls_w == OP_SUBF);
      wire logic [31:0] wv_w = ({20'h00000, fsr_r} & ~mask_w)
        | (wb_req_in.dat & mask_w);
      always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
          fsr_r <= '0;
        end else if (hit_w) begin
          fsr_r <= wv_w[DM_AW-1:0];
        end else if (lit_w) begin
          fsr_r <= (cls_w == OP_ADDF) ? fsr_r + k6_w : fsr_r - k6_w;
        end else if (gi == 2 && push_w) begin
          fsr_r <= fsr_r - DM_AW'(1);
        end
      end
      assign fsr_w[gi] = fsr_r;
    end
  endgenerate

  // Register readback
  wire logic [31:0] stat_w = {16'h0000, 8'(sp_r), 6'h00, ill_r, !idle_w};
  wire logic [31:0] rd_mux_w =
    (adr_w == `CBX_ADR_CTRL) ? {31'h00000000, ext_en_r} :
    (adr_w == `CBX_ADR_FLAGS) ? {27'h0000000, flags_r} :
    (adr_w == `CBX_ADR_PC) ? {11'h000, pc_r} :
    (adr_w == `CBX_ADR_WORKING_REGISTER) ? {24'h000000, working_register_r} :
    (adr_w == `CBX_ADR_BSR) ? 32'(bsr_r) :
    (adr_w == `CBX_ADR_PC_HIGH_LATCH) ? {24'h000000, pc_high_latch_r} :
    (adr_w == `CBX_ADR_PC_UPPER_LATCH) ? {27'h0000000, pc_upper_latch_r} :
    (adr_w == `CBX_ADR_FSR0) ? 32'(fsr_w[0]) :
    (adr_w == `CBX_ADR_FSR1) ? 32'(fsr_w[1]) :
    (adr_w == `CBX_ADR_STACK_FRAME_POINTER) ? 32'(fsr_w[2]) :
    (adr_w == `CBX_ADR_INSTR2) ? {16'h0000, ins2_r} :
    (adr_w == `CBX_ADR_INSTR) ? {16'h0000, ins_r} :
    (adr_w == `CBX_ADR_STAT) ? stat_w :
    (adr_w == `CBX_ADR_ICNT) ? icnt_r :
    (adr_w == `CBX_ADR_MADDR) ? 32'(maddr_r) :
    (adr_w == `CBX_ADR_MDATA) ? {24'h000000, dm_rd} : 32'h00000000;
  wire logic [31:0] wv_w = (rd_mux_w & ~mask_w) | (wb_req_in.dat & mask_w);
  wire logic clr_ill_w = bw_w && adr_w == `CBX_ADR_STAT
    && wb_req_in.sel[0] && wb_req_in.dat[`CBX_STAT_ILL_BIT];

  // Bus handshake and answer
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h00000000;
    end else begin
      ack_r <= req_w;
      rdat_r <= (req_w && !wb_req_in.we) ? rd_mux_w : 32'h00000000;
    end
  end
  assign wb_rsp_out = '{ack: ack_r, dat: rdat_r};

  // Core state and software-visible registers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_r <= ST_IDLE;
      pc_r <= `CBX_RST_PC;
      sp_r <= '0;
      ill_r <= 1'b0;
      icnt_r <= 32'h00000000;
    end else begin
      st_r <= st_nxt;
      pc_r <= (bw_w && adr_w == `CBX_ADR_PC) ? wv_w[20:0] : pc_nxt;
      sp_r <= sp_nxt;
      ill_r <= ill_set || (ill_r && !clr_ill_w);
      // Bit invert spends its first cycle fetching the operand, so only one counts
      icnt_r <= icnt_r + (((ex_exe_w && !btg_w) || ex_sec_w) ? 32'h1 : 32'h0);
    end
  end

  // Configuration and operand registers, written only while idle
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ext_en_r <= `CBX_RST_EXT;
      flags_r <= '0;
      working_register_r <= `CBX_RST_BYTE;
      bsr_r <= '0;
      pc_high_latch_r <= `CBX_RST_BYTE;
      pc_upper_latch_r <= '0;
      ins_r <= 16'h0000;
      ins2_r <= 16'h0000;
      maddr_r <= '0;
    end else if (bw_w) begin
      case (adr_w)
        `CBX_ADR_CTRL: ext_en_r <= wv_w[`CBX_CTRL_EXT_BIT];
        `CBX_ADR_FLAGS: flags_r <= wv_w[4:0];
        `CBX_ADR_WORKING_REGISTER: working_register_r <= wv_w[7:0];
        `CBX_ADR_BSR: bsr_r <= wv_w[BW-1:0];
        `CBX_ADR_PC_HIGH_LATCH: pc_high_latch_r <= wv_w[7:0];
        `CBX_ADR_PC_UPPER_LATCH: pc_upper_latch_r <= wv_w[4:0];
        `CBX_ADR_INSTR2: ins2_r <= wv_w[15:0];
        `CBX_ADR_INSTR: ins_r <= wv_w[15:0];
        `CBX_ADR_MADDR: maddr_r <= wv_w[DM_AW-1:0];
        default: ;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  chk_bnc_branch: assert property (
    ex_exe_w && cls_w == OP_BNC && !flags_r.c |=>
      st_r == ST_SEC && pc_r == $past(pc_r) + 21'h2 + $past(boff_w))
    else $error("carry-clear branch not taken");
  chk_bnn_branch: assert property (
    ex_exe_w && cls_w == OP_BNN && flags_r.n |=> st_r == ST_IDLE
      && pc_r == $past(pc_r) + 21'h2)
    else $error("not-negative branch taken wrongly");
  chk_bov_branch: assert property (
    ex_exe_w && cls_w == OP_BOV && flags_r.ov |=> ##1 st_r == ST_IDLE)
    else $error("overflow branch wrong length");
  chk_flags_kept: assert property (
    !idle_w |=> $stable(flags_r))
    else $error("status flags changed by execution");
  chk_bit_invert: assert property (
    ex_exe_w && btg_w |=> dm_we_w && dm_wa_w == $past(ea_w)
      && (dm_wd_w ^ dm_rd) == (8'h01 << $past(bsel_w)))
    else $error("bit invert wrong");
  chk_bank_sel: assert property (
    ex_exe_w && btg_w && acc_w |-> ea_w[DM_AW-1:8] == bsr_r)
    else $error("bank select not used");
  chk_access_bank: assert property (
    ex_exe_w && btg_w && !acc_w && !ilo_w |-> ea_w[DM_AW-1:8]
      == ((lo_w >= 8'h60) ? {BW{1'b1}} : {BW{1'b0}}))
    else $error("access bank wrong");
  chk_indexed_ea: assert property (
    ex_exe_w && btg_w && ext_en_r && !acc_w && lo_w <= 8'h5F |->
      ea_w == stack_frame_pointer_w + DM_AW'(lo_w))
    else $error("indexed literal offset wrong");
  chk_std_only: assert property (
    !ext_en_r |-> !(cls_w inside {OP_ADDF, OP_SUBF, OP_PUSH_LITERAL_OP, OP_CALL_VIA_WORKING_REG,
      OP_INDEXED_TO_FILE_MOVE, OP_INDEXED_TO_INDEXED_MOVE}))
    else $error("extended op decoded while disabled");
  chk_frame_ret: assert property (
    ex_exe_w && cls_w == OP_ADDF && ulnk_w |=> pc_r == $past(stk_rd)
      && stack_frame_pointer_w == $past(stack_frame_pointer_w) + $past(k6_w) ##1 idle_w)
    else $error("frame add and return wrong");
  chk_push_lit: assert property (
    push_w |-> dm_we_w && dm_wa_w == stack_frame_pointer_w ##1 stack_frame_pointer_w == $past(stack_frame_pointer_w) - 12'h1)
    else $error("push literal wrong");
  chk_call_reg: assert property (
    ex_exe_w && cls_w == OP_CALL_VIA_WORKING_REG |=> ex_sec_w
      && pc_r == {$past(pc_upper_latch_r), $past(pc_high_latch_r), $past(working_register_r)} ##1 idle_w)
    else $error("call via working register wrong");
  chk_move_len: assert property (
    ex_exe_w && movs_w |=> secwr_w ##1 idle_w && pc_r == $past(pc_r, 2) + 21'h4)
    else $error("indexed move wrong length");

  cov_branch_taken: cover property (ex_exe_w && take_w);
  cov_bit_invert: cover property (ex_exe_w && btg_w && ilo_w);
  cov_frame_ret: cover property (ex_exe_w && cls_w == OP_SUBF && ulnk_w);
  cov_move_idx: cover property (ex_exe_w && cls_w == OP_INDEXED_TO_INDEXED_MOVE);

endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the branch and indexed-op unit, driven over its register bus.
// Assumes cbx_pkg is compiled first and cbx_cfg.svh is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "cbx_cfg.svh"
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL t=%0t %s got %h exp %h", $time, m, g, e); end end
module testbench;
  import cbx_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  cbx_wb_req_t wb_req = '0;
  cbx_wb_rsp_t wb_rsp;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] rdat;
  logic [31:0] cnt0;
  logic [31:0] exp_pc;
  // Branch cases: opcode byte, flag setting, offset, taken
  logic [7:0] br_op [6] = '{8'hE3, 8'hE3, 8'hE7, 8'hE7, 8'hE4, 8'hE4};
  logic [4:0] br_flg [6] = '{5'h01, 5'h1E, 5'h10, 5'h0F, 5'h08, 5'h17};
  logic [7:0] br_off [6] = '{8'h80, 8'h7F, 8'h80, 8'h7F, 8'h80, 8'h7F};
  logic br_tk [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  // Bit-invert cases: bit, access bit, file address, resolved address
  logic [2:0] bt_b [3] = '{3'h7, 3'h0, 3'h3};
  logic bt_a [3] = '{1'b0, 1'b1, 1'b0};
  logic [7:0] bt_f [3] = '{8'h05, 8'h34, 8'h70};
  logic [11:0] bt_ea [3] = '{12'h005, 12'h234, 12'hF70};
  // Frame return cases: opcode and resulting frame pointer
  logic [15:0] ret_op [2] = '{16'hE8C5, 16'hE9C3};
  logic [31:0] ret_fsr [2] = '{32'h085, 32'h07D};

  cbx_exec dut (
    .core_clk_in(core_clk),
    .sys_rst_in(sys_rst),
    .wb_req_in(wb_req),
    .wb_rsp_out(wb_rsp)
  );

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      $display("FAIL t=%0t bench timeout", $time);
      print_verdict();
    end
  end

  // Closing report
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One classic cycle: hold until ack is sampled, then release for a cycle
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 20);
    rdat = wb_rsp.dat;
    if (wb_rsp.ack !== 1'b1) begin
      bad_count++;
      $display("FAIL t=%0t no bus answer", $time);
    end
    wb_req <= '0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    `CHK(rdat, e, m)
  endtask

  // Data memory reached through the address and data windows
  task automatic mem_wr(input logic [11:0] a, input logic [7:0] v);
    wr(`CBX_ADR_MADDR, {20'h0, a});
    wr(`CBX_ADR_MDATA, {24'h0, v});
  endtask

  task automatic mem_chk(input logic [11:0] a, input logic [7:0] e, input string m);
    wr(`CBX_ADR_MADDR, {20'h0, a});
    chk_rd(`CBX_ADR_MDATA, {24'h0, e}, m);
  endtask

  // Runs one instruction and checks how many cycles it took
  task automatic exec(input logic [15:0] instr, input int ncyc);
    bus(1'b0, `CBX_ADR_ICNT, 32'h0);
    cnt0 = rdat;
    wr(`CBX_ADR_INSTR, {16'h0, instr});
    chk_rd(`CBX_ADR_ICNT, cnt0 + 32'(ncyc), "cycle count");
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    chk_rd(`CBX_ADR_PC, 32'h0, "pc reset");
    chk_rd(`CBX_ADR_CTRL, 32'h0, "extended enable reset");
    chk_rd(`CBX_ADR_FLAGS, 32'h0, "flags reset");
    chk_rd(8'h40, 32'h0, "unmapped read");
    // Conditional branches at both offset limits, taken and not
    for (int i = 0; i < 6; i++) begin
      wr(`CBX_ADR_PC, 32'h100);
      wr(`CBX_ADR_FLAGS, {27'h0, br_flg[i]});
      exec({br_op[i], br_off[i]}, br_tk[i] ? 2 : 1);
      exp_pc = br_tk[i] ? 32'h102 + {{23{br_off[i][7]}}, br_off[i], 1'b0} : 32'h102;
      chk_rd(`CBX_ADR_PC, exp_pc, "branch target");
      chk_rd(`CBX_ADR_FLAGS, {27'h0, br_flg[i]}, "branch flags");
    end
    // Bit invert over access bank and banked addressing, twice to toggle back
    wr(`CBX_ADR_BSR, 32'h2);
    for (int i = 0; i < 3; i++) begin
      mem_wr(bt_ea[i], 8'h00);
      exec({4'h7, bt_b[i], bt_a[i], bt_f[i]}, 1);
      mem_chk(bt_ea[i], 8'h01 << bt_b[i], "bit invert set");
      exec({4'h7, bt_b[i], bt_a[i], bt_f[i]}, 1);
      mem_chk(bt_ea[i], 8'h00, "bit invert clear");
    end
    // Extended opcode refused while the extended set is off
    wr(`CBX_ADR_FSR0, 32'h10);
    exec(16'hE801, 1);
    chk_rd(`CBX_ADR_FSR0, 32'h10, "pointer kept");
    bus(1'b0, `CBX_ADR_STAT, 32'h0);
    `CHK(rdat[1], 1'b1, "illegal flag")
    wr(`CBX_ADR_STAT, 32'h2);
    // Pointer add and subtract, including wrap below zero
    wr(`CBX_ADR_CTRL, 32'h1);
    wr(`CBX_ADR_FSR1, 32'h0);
    wr(`CBX_ADR_PC, 32'h100);
    exec(16'hE83F, 1);
    exec(16'hE941, 1);
    chk_rd(`CBX_ADR_FSR0, 32'h4F, "pointer add");
    chk_rd(`CBX_ADR_FSR1, 32'hFFF, "pointer sub");
    chk_rd(`CBX_ADR_PC, 32'h104, "pointer op pc");
    // Push literal at the frame pointer
    wr(`CBX_ADR_STACK_FRAME_POINTER, 32'h100);
    exec(16'hEAA5, 1);
    mem_chk(12'h100, 8'hA5, "pushed byte");
    chk_rd(`CBX_ADR_STACK_FRAME_POINTER, 32'hFF, "frame pointer down");
    // Bit invert in indexed mode goes through the frame pointer
    wr(`CBX_ADR_STACK_FRAME_POINTER, 32'h80);
    mem_wr(12'h085, 8'h00);
    exec({4'h7, 3'h2, 1'b0, 8'h05}, 1);
    mem_chk(12'h085, 8'h04, "indexed invert");
    // Call through working register, then each frame return form
    wr(`CBX_ADR_WORKING_REGISTER, 32'h06);
    wr(`CBX_ADR_PC_HIGH_LATCH, 32'h10);
    wr(`CBX_ADR_PC_UPPER_LATCH, 32'h01);
    wr(`CBX_ADR_FLAGS, 32'h1F);
    for (int i = 0; i < 2; i++) begin
      wr(`CBX_ADR_PC, 32'h10);
      wr(`CBX_ADR_STACK_FRAME_POINTER, 32'h80);
      exec(16'h0014, 2);
      chk_rd(`CBX_ADR_PC, 32'h011006, "call target");
      chk_rd(`CBX_ADR_STAT, 32'h100, "stack depth one");
      exec(ret_op[i], 2);
      chk_rd(`CBX_ADR_PC, 32'h12, "return address");
      chk_rd(`CBX_ADR_STACK_FRAME_POINTER, ret_fsr[i], "frame adjust");
      chk_rd(`CBX_ADR_STAT, 32'h0, "stack empty");
    end
    chk_rd(`CBX_ADR_FLAGS, 32'h1F, "flags kept");
    // Indexed to file, then indexed to indexed
    wr(`CBX_ADR_STACK_FRAME_POINTER, 32'h80);
    mem_wr(12'h085, 8'h33);
    mem_wr(12'h123, 8'h00);
    mem_wr(12'h090, 8'h00);
    wr(`CBX_ADR_PC, 32'h200);
    wr(`CBX_ADR_INSTR2, 32'hF123);
    exec(16'hEB05, 2);
    mem_chk(12'h123, 8'h33, "move to file");
    chk_rd(`CBX_ADR_PC, 32'h204, "two-word pc");
    wr(`CBX_ADR_INSTR2, 32'hF010);
    exec(16'hEB85, 2);
    mem_chk(12'h090, 8'h33, "move indexed");
    print_verdict();
  end
endmodule
`default_nettype wire
